// file: src/gpm_pkg.sv
// Shared constants for the GPIO pin function multiplexer
package gpm_pkg;
    // Pin index layout: port A 0-7, port B 8-15, port C 16-23, port D 24-27
    localparam int NPIN   = 28;
    localparam int PA_W   = 6;
    localparam int PB_W   = 8;
    localparam int PC_W   = 8;
    localparam int PD_W   = 4;
    localparam int A3     = 3;
    localparam int A4     = 4;
    localparam int A6     = 6;
    localparam int A7     = 7;
    localparam int B0     = 8;
    localparam int B1     = 9;
    localparam int B2     = 10;
    localparam int B4     = 12;
    localparam int B5     = 13;
    localparam int B6     = 14;
    localparam int B7     = 15;
    localparam int C0     = 16;
    localparam int D0     = 24;

    ////////////////////////////////////////////////////////////////////////
    // Bonded pins: A3 and A6 have no package pin
    localparam logic [NPIN-1:0] BONDED  = 28'hfffffb7;
    // Function enables after reset: A7 reset, C analog, D JTAG
    localparam logic [NPIN-1:0] FN_RST  = 28'hfff0080;
    // Synchroniser reset: the reset pin reads released
    localparam logic [NPIN-1:0] SYNC_RST = 28'h0000080;

    ////////////////////////////////////////////////////////////////////////
    // Select field encodings, first alternative is zero
    localparam logic [1:0] SEL_PWM   = 2'h0;
    localparam logic [1:0] SEL_FAULT = 2'h1;
    localparam logic [1:0] SEL_TIMER = 2'h2;
    localparam logic [1:0] SEL_A_RST = 2'h0;
    localparam logic [7:0] SEL_B_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Inactive values seen by deselected peripherals
    localparam logic [3:0] FAULT_IDLE = 4'h0;
    localparam logic [3:0] TIMER_IDLE = 4'h0;
    localparam logic [3:0] SPI_IDLE   = 4'h2;
    localparam logic [1:0] I2C_IDLE   = 2'h3;
    localparam logic       UART_IDLE  = 1'h1;
    localparam logic       RSTN_IDLE  = 1'h1;
    localparam logic [2:0] JTAG_IDLE  = 3'h5;
endpackage

// file: src/gpm_sync_if.sv
// Raw and filtered pin levels between the mux and its synchroniser
`timescale 1ns/1ps
interface gpm_sync_if;
    logic [gpm_pkg::NPIN-1:0] raw;
    logic [gpm_pkg::NPIN-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface

// file: src/gpm_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module gpm_pin_sync (
    input  logic   core_clk,
    input  logic   sys_rst,
    gpm_sync_if.sync bus
);
    typedef struct packed {
        logic [gpm_pkg::NPIN-1:0] s1;
        logic [gpm_pkg::NPIN-1:0] s2;
        logic [gpm_pkg::NPIN-1:0] s3;
        logic [gpm_pkg::NPIN-1:0] clean;
    } gpm_sync_s;

    gpm_sync_s q_reg;
    gpm_sync_s q_next;

    ////////////////////////////////////////////////////////////////////////
    // Stage one only feeds stage two; a change counts once two and three agree
    always_comb begin
        q_next = q_reg;
        q_next.s1 = bus.raw;
        q_next.s2 = q_reg.s1;
        q_next.s3 = q_reg.s2;
        for (int i = 0; i < gpm_pkg::NPIN; i++) begin
            if (q_reg.s2[i] == q_reg.s3[i]) begin
                q_next.clean[i] = q_reg.s2[i];
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q_reg <= {4{gpm_pkg::SYNC_RST}};
        end else begin
            q_reg <= q_next;
        end
    end

    assign bus.clean = q_reg.clean;
endmodule

// file: src/gpm_pin_mux.sv
// Pin function multiplexer for ports A to D
// Behaviour
// - Four ports of 6, 8, 8, 4 usable pins, shared with peripheral functions.
// - Reset: A is GPIO except bit 7 reset, B GPIO, C analog, D JTAG.
// - A4/A5 pick PWM, fault input or timer channel by select field.
// - B0 picks SPI clock or I2C clock; B1 picks SPI select or I2C data.
// - B2/B3 pick SPI MISO/MOSI or timer channels two/three.
// - B4 picks timer channel zero or the clock output.
// - B5 picks timer channel one or PWM fault input three.
// - B6 picks UART receive or I2C data; B7 UART transmit or I2C clock.
// - External clock input on B6 follows its own enable, not the select.
// - A3 and A6 exist, default GPIO, but drive and sample nothing.
`timescale 1ns/1ps
module gpm_pin_mux (
    input  logic                     core_clk,
    input  logic                     sys_rst,
    input  logic [gpm_pkg::NPIN-1:0] pin_in,
    output logic [gpm_pkg::NPIN-1:0] pin_out,
    output logic [gpm_pkg::NPIN-1:0] pin_oe,
    input  logic [gpm_pkg::NPIN-1:0] periph_en,
    input  logic [1:0]               sel_a4,
    input  logic [1:0]               sel_a5,
    input  logic [7:0]               sel_b,
    input  logic                     ext_clk_en,
    input  logic [gpm_pkg::NPIN-1:0] gpio_out,
    input  logic [gpm_pkg::NPIN-1:0] gpio_oe,
    output logic [gpm_pkg::NPIN-1:0] gpio_in,
    input  logic [5:0]               pwm_out,
    output logic [3:0]               pwm_fault_in,
    input  logic [3:0]               timer_out,
    input  logic [3:0]               timer_oe,
    output logic [3:0]               timer_in,
    input  logic [3:0]               spi_out,
    input  logic [3:0]               spi_oe,
    output logic [3:0]               spi_in,
    input  logic [1:0]               i2c_out,
    input  logic [1:0]               i2c_oe,
    output logic [1:0]               i2c_in,
    input  logic                     uart_tx_out,
    output logic                     uart_rx_in,
    input  logic                     clk_out_src,
    output logic                     ext_clk_in,
    output logic                     reset_in_n,
    output logic [7:0]               adc_pin_en,
    input  logic                     jtag_tdo_out,
    input  logic                     jtag_tdo_oe,
    output logic [2:0]               jtag_in
);
    typedef struct packed {
        logic [1:0]               sel_a4;
        logic [1:0]               sel_a5;
        logic [7:0]               sel_b;
        logic [gpm_pkg::NPIN-1:0] fn;
        logic                     ext_en;
        logic [gpm_pkg::NPIN-1:0] pin_out;
        logic [gpm_pkg::NPIN-1:0] pin_oe;
        logic [gpm_pkg::NPIN-1:0] gpio_in;
        logic [3:0]               fault_in;
        logic [3:0]               timer_in;
        logic [3:0]               spi_in;
        logic [1:0]               i2c_in;
        logic                     uart_rx;
        logic                     ext_clk;
        logic                     rst_n;
        logic [7:0]               adc_en;
        logic [2:0]               jtag_in;
    } gpm_state_s;

    gpm_state_s q_reg;
    gpm_state_s q_next;
    gpm_sync_if sync_bus ();
    logic [gpm_pkg::NPIN-1:0] cin;

    assign sync_bus.raw = pin_in;
    assign cin          = sync_bus.clean;

    gpm_pin_sync u_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .bus      (sync_bus.sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Routing works from the previous cycle's selects, so one cycle of latency
    always_comb begin
        q_next        = q_reg;
        q_next.sel_a4 = sel_a4;
        q_next.sel_a5 = sel_a5;
        q_next.sel_b  = sel_b;
        q_next.fn     = periph_en;
        q_next.ext_en = ext_clk_en;
        // GPIO owns every pin unless its function enable is set, or for B6 the external clock enable
        q_next.pin_out  = gpio_out;
        q_next.pin_oe   = gpio_oe;
        q_next.gpio_in  = cin;
        q_next.fault_in = gpm_pkg::FAULT_IDLE;
        q_next.timer_in = gpm_pkg::TIMER_IDLE;
        q_next.spi_in   = gpm_pkg::SPI_IDLE;
        q_next.i2c_in   = gpm_pkg::I2C_IDLE;
        q_next.uart_rx  = gpm_pkg::UART_IDLE;
        q_next.rst_n    = gpm_pkg::RSTN_IDLE;
        q_next.jtag_in  = gpm_pkg::JTAG_IDLE;
        q_next.ext_clk  = 1'h0;
        // Port A: PWM on bits 0 to 2, reset input on bit 7
        for (int i = 0; i < 3; i++) begin
            if (q_reg.fn[i]) begin
                q_next.pin_out[i] = pwm_out[i];
                q_next.pin_oe[i]  = 1'h1;
            end
        end
        if (q_reg.fn[gpm_pkg::A7]) begin
            q_next.pin_oe[gpm_pkg::A7] = 1'h0;
            q_next.rst_n               = cin[gpm_pkg::A7];
        end
        // Port B, bits 6 and 7 first so bits 0 and 1 win a doubled I2C line
        if (q_reg.fn[gpm_pkg::B6]) begin
            q_next.pin_oe[gpm_pkg::B6] = 1'h0;
            if (q_reg.sel_b[6]) begin
                q_next.pin_out[gpm_pkg::B6] = i2c_out[1];
                q_next.pin_oe[gpm_pkg::B6]  = i2c_oe[1];
                q_next.i2c_in[1]            = cin[gpm_pkg::B6];
            end else begin
                q_next.uart_rx = cin[gpm_pkg::B6];
            end
        end
        if (q_reg.fn[gpm_pkg::B7]) begin
            if (q_reg.sel_b[7]) begin
                q_next.pin_out[gpm_pkg::B7] = i2c_out[0];
                q_next.pin_oe[gpm_pkg::B7]  = i2c_oe[0];
                q_next.i2c_in[0]            = cin[gpm_pkg::B7];
            end else begin
                q_next.pin_out[gpm_pkg::B7] = uart_tx_out;
                q_next.pin_oe[gpm_pkg::B7]  = 1'h1;
            end
        end
        // B0 and B1: SPI clock and select, or I2C clock and data
        for (int j = 0; j < 2; j++) begin
            if (q_reg.fn[gpm_pkg::B0+j]) begin
                if (q_reg.sel_b[j]) begin
                    q_next.pin_out[gpm_pkg::B0+j] = i2c_out[j];
                    q_next.pin_oe[gpm_pkg::B0+j]  = i2c_oe[j];
                    q_next.i2c_in[j]              = cin[gpm_pkg::B0+j];
                end else begin
                    q_next.pin_out[gpm_pkg::B0+j] = spi_out[j];
                    q_next.pin_oe[gpm_pkg::B0+j]  = spi_oe[j];
                    q_next.spi_in[j]              = cin[gpm_pkg::B0+j];
                end
            end
        end
        // B2 and B3: SPI data or timer channels two and three
        for (int j = 0; j < 2; j++) begin
            if (q_reg.fn[gpm_pkg::B2+j]) begin
                if (q_reg.sel_b[2+j]) begin
                    q_next.pin_out[gpm_pkg::B2+j] = timer_out[2+j];
                    q_next.pin_oe[gpm_pkg::B2+j]  = timer_oe[2+j];
                    q_next.timer_in[2+j]          = cin[gpm_pkg::B2+j];
                end else begin
                    q_next.pin_out[gpm_pkg::B2+j] = spi_out[2+j];
                    q_next.pin_oe[gpm_pkg::B2+j]  = spi_oe[2+j];
                    q_next.spi_in[2+j]            = cin[gpm_pkg::B2+j];
                end
            end
        end
        if (q_reg.fn[gpm_pkg::B4]) begin
            if (q_reg.sel_b[4]) begin
                q_next.pin_out[gpm_pkg::B4] = clk_out_src;
                q_next.pin_oe[gpm_pkg::B4]  = 1'h1;
            end else begin
                q_next.pin_out[gpm_pkg::B4] = timer_out[0];
                q_next.pin_oe[gpm_pkg::B4]  = timer_oe[0];
                q_next.timer_in[0]          = cin[gpm_pkg::B4];
            end
        end
        if (q_reg.fn[gpm_pkg::B5]) begin
            if (q_reg.sel_b[5]) begin
                q_next.pin_oe[gpm_pkg::B5] = 1'h0;
                q_next.fault_in[3]         = cin[gpm_pkg::B5];
            end else begin
                q_next.pin_out[gpm_pkg::B5] = timer_out[1];
                q_next.pin_oe[gpm_pkg::B5]  = timer_oe[1];
                q_next.timer_in[1]          = cin[gpm_pkg::B5];
            end
        end
        // External clock takes B6 as an input whatever the select says
        if (q_reg.ext_en) begin
            q_next.pin_oe[gpm_pkg::B6] = 1'h0;
            q_next.ext_clk             = cin[gpm_pkg::B6];
        end
        // A4 and A5 after port B: they win timer inputs shared with B2 and B3
        for (int j = 0; j < 2; j++) begin
            if (q_reg.fn[gpm_pkg::A4+j]) begin
                case (j == 0 ? q_reg.sel_a4 : q_reg.sel_a5)
                    gpm_pkg::SEL_FAULT: begin
                        q_next.pin_oe[gpm_pkg::A4+j] = 1'h0;
                        q_next.fault_in[1+j]         = cin[gpm_pkg::A4+j];
                    end
                    gpm_pkg::SEL_TIMER: begin
                        q_next.pin_out[gpm_pkg::A4+j] = timer_out[2+j];
                        q_next.pin_oe[gpm_pkg::A4+j]  = timer_oe[2+j];
                        q_next.timer_in[2+j]          = cin[gpm_pkg::A4+j];
                    end
                    default: begin
                        q_next.pin_out[gpm_pkg::A4+j] = pwm_out[4+j];
                        q_next.pin_oe[gpm_pkg::A4+j]  = 1'h1;
                    end
                endcase
            end
        end
        // Port C analog: digital driver off, converter input enabled
        q_next.adc_en = q_reg.fn[gpm_pkg::C0 +: gpm_pkg::PC_W];
        for (int i = 0; i < gpm_pkg::PC_W; i++) begin
            if (q_reg.fn[gpm_pkg::C0+i]) begin
                q_next.pin_out[gpm_pkg::C0+i] = 1'h0;
                q_next.pin_oe[gpm_pkg::C0+i]  = 1'h0;
            end
        end
        // Port D JTAG: bit 1 is the data out, the rest are inputs
        for (int i = 0; i < gpm_pkg::PD_W; i++) begin
            if (q_reg.fn[gpm_pkg::D0+i]) begin
                q_next.pin_oe[gpm_pkg::D0+i] = 1'h0;
            end
        end
        if (q_reg.fn[gpm_pkg::D0+1]) begin
            q_next.pin_out[gpm_pkg::D0+1] = jtag_tdo_out;
            q_next.pin_oe[gpm_pkg::D0+1]  = jtag_tdo_oe;
        end
        if (q_reg.fn[gpm_pkg::D0]) begin
            q_next.jtag_in[0] = cin[gpm_pkg::D0];
        end
        if (q_reg.fn[gpm_pkg::D0+2]) begin
            q_next.jtag_in[1] = cin[gpm_pkg::D0+2];
        end
        if (q_reg.fn[gpm_pkg::D0+3]) begin
            q_next.jtag_in[2] = cin[gpm_pkg::D0+3];
        end
        // Unbonded pins keep their logic but touch nothing outside
        q_next.pin_out = q_next.pin_out & gpm_pkg::BONDED;
        q_next.pin_oe  = q_next.pin_oe & gpm_pkg::BONDED;
        q_next.gpio_in = q_next.gpio_in & gpm_pkg::BONDED;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q_reg        <= '0;
            q_reg.sel_a4 <= gpm_pkg::SEL_A_RST;
            q_reg.sel_a5 <= gpm_pkg::SEL_A_RST;
            q_reg.sel_b  <= gpm_pkg::SEL_B_RST;
            q_reg.fn     <= gpm_pkg::FN_RST;
            q_reg.fault_in <= gpm_pkg::FAULT_IDLE;
            q_reg.spi_in   <= gpm_pkg::SPI_IDLE;
            q_reg.i2c_in   <= gpm_pkg::I2C_IDLE;
            q_reg.uart_rx  <= gpm_pkg::UART_IDLE;
            q_reg.rst_n    <= gpm_pkg::RSTN_IDLE;
            q_reg.jtag_in  <= gpm_pkg::JTAG_IDLE;
            q_reg.adc_en   <= gpm_pkg::FN_RST[gpm_pkg::C0 +: gpm_pkg::PC_W];
        end else begin
            q_reg <= q_next;
        end
    end

    assign pin_out      = q_reg.pin_out;
    assign pin_oe       = q_reg.pin_oe;
    assign gpio_in      = q_reg.gpio_in;
    assign pwm_fault_in = q_reg.fault_in;
    assign timer_in     = q_reg.timer_in;
    assign spi_in       = q_reg.spi_in;
    assign i2c_in       = q_reg.i2c_in;
    assign uart_rx_in   = q_reg.uart_rx;
    assign ext_clk_in   = q_reg.ext_clk;
    assign reset_in_n   = q_reg.rst_n;
    assign adc_pin_en   = q_reg.adc_en;
    assign jtag_in      = q_reg.jtag_in;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic chk_first_q;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            chk_first_q <= 1'h1;
        end else begin
            chk_first_q <= 1'h0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_a4_pwm;
        q_reg.fn[gpm_pkg::A4] && q_reg.sel_a4 == gpm_pkg::SEL_PWM;
    endsequence
    sequence s_b5_fault;
        q_reg.fn[gpm_pkg::B5] && q_reg.sel_b[5];
    endsequence

    chk_reset_defaults: assert property (chk_first_q |-> q_reg.fn == gpm_pkg::FN_RST && pin_oe == '0
        && q_reg.sel_a4 == gpm_pkg::SEL_PWM && q_reg.sel_b == 8'h00 && reset_in_n) else $error("bad reset state");
    chk_sel_reset_zero: assert property (chk_first_q |-> q_reg.sel_a5 == gpm_pkg::SEL_PWM)
        else $error("select field not reset to first choice");
    chk_a4_pwm_route: assert property (s_a4_pwm |=> pin_oe[gpm_pkg::A4] && pin_out[gpm_pkg::A4] == $past(pwm_out[4]))
        else $error("A4 PWM not routed");
    chk_b0_spi_clock: assert property (q_reg.fn[gpm_pkg::B0] && !q_reg.sel_b[0]
        && !(q_reg.fn[gpm_pkg::B7] && q_reg.sel_b[7]) |=>
        pin_out[gpm_pkg::B0] == $past(spi_out[0]) && i2c_in[0] == 1'h1) else $error("B0 SPI clock misrouted");
    chk_b2_timer_two: assert property (q_reg.fn[gpm_pkg::B2] && q_reg.sel_b[2] && !q_reg.fn[gpm_pkg::A4] |=>
        pin_oe[gpm_pkg::B2] == $past(timer_oe[2]) && timer_in[2] == $past(cin[gpm_pkg::B2]))
        else $error("B2 timer misrouted");
    chk_b4_clock_out: assert property (q_reg.fn[gpm_pkg::B4] && q_reg.sel_b[4] |=>
        pin_oe[gpm_pkg::B4] && pin_out[gpm_pkg::B4] == $past(clk_out_src)) else $error("B4 clock output misrouted");
    chk_b5_fault_in: assert property (s_b5_fault ##1 s_b5_fault |->
        !pin_oe[gpm_pkg::B5] && pwm_fault_in[3] == $past(cin[gpm_pkg::B5])) else $error("B5 fault input misrouted");
    chk_b7_uart_tx: assert property (q_reg.fn[gpm_pkg::B7] && !q_reg.sel_b[7] |=>
        pin_out[gpm_pkg::B7] == $past(uart_tx_out) && pin_oe[gpm_pkg::B7]) else $error("B7 UART transmit misrouted");
    chk_ext_clock_in: assert property (ext_clk_en |=> ##1 ext_clk_in == $past(cin[gpm_pkg::B6])
        && !pin_oe[gpm_pkg::B6]) else $error("external clock input wrong");
    chk_unbonded_quiet: assert property (!pin_oe[gpm_pkg::A3] && !pin_oe[gpm_pkg::A6]
        && !pin_out[gpm_pkg::A6] && !gpio_in[gpm_pkg::A3]) else $error("unbonded pin active");
    chk_gpio_owns_pin: assert property (!q_reg.fn[gpm_pkg::B1] |=>
        pin_out[gpm_pkg::B1] == $past(gpio_out[gpm_pkg::B1]) && spi_in[1] == 1'h1) else $error("GPIO lost B1");
    chk_port_b_width: assert property (q_reg.fn[gpm_pkg::B0 +: gpm_pkg::PB_W] == '0 |=>
        pin_oe[gpm_pkg::B0 +: gpm_pkg::PB_W] == $past(gpio_oe[gpm_pkg::B0 +: gpm_pkg::PB_W]))
        else $error("port B not under GPIO");
endmodule

// file: verification/gpm_pin_model.sv
// Package pin model: resolves each pin from the mux drive and an outside driver
`timescale 1ns/1ps
module gpm_pin_model (
    input  logic [gpm_pkg::NPIN-1:0] pin_out,
    input  logic [gpm_pkg::NPIN-1:0] pin_oe,
    input  logic [gpm_pkg::NPIN-1:0] ext_val,
    input  logic [gpm_pkg::NPIN-1:0] ext_en,
    output logic [gpm_pkg::NPIN-1:0] pin_in
);
    // Undriven pins float to the pull-up, never to the last value
    always_comb begin
        pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | ~ext_en));
    end
endmodule

// file: verification/gpio_port_pin_function_mux_tb.sv
// Self-checking bench for the pin function multiplexer
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module gpio_port_pin_function_mux_tb;
    // Select edge, pin register, three sync stages, filter and output register
    localparam int LAT = 7;
    logic                     core_clk = 1'b0;
    logic                     sys_rst = 1'b1;
    logic [gpm_pkg::NPIN-1:0] pin_in, pin_out, pin_oe, ext_val, ext_en;
    logic [gpm_pkg::NPIN-1:0] periph_en = gpm_pkg::FN_RST;
    logic [gpm_pkg::NPIN-1:0] gpio_out = '0, gpio_oe = '0, gpio_in;
    logic [1:0]               sel_a4 = 2'h0, sel_a5 = 2'h0, i2c_out = 2'h2, i2c_oe = 2'h3, i2c_in;
    logic [7:0]               sel_b = 8'h00, adc_pin_en;
    logic                     ext_clk_en = 1'b0, uart_tx_out = 1'b1, clk_out_src = 1'b0;
    logic                     jtag_tdo_out = 1'b1, jtag_tdo_oe = 1'b1, uart_rx_in, ext_clk_in, reset_in_n;
    logic [5:0]               pwm_out = 6'h30;
    logic [3:0]               pwm_fault_in, timer_in, spi_in;
    logic [3:0]               timer_out = 4'h5, timer_oe = 4'hf, spi_out = 4'ha, spi_oe = 4'hf;
    logic [2:0]               jtag_in;
    int                       num_errors = 0;
    int                       num_checks = 0;

    always #12.5 core_clk = ~core_clk;

    initial begin
        ext_val = '0;
        ext_en  = '0;
    end

    gpm_pin_model gpm_pin_model_inst (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
        .ext_en(ext_en), .pin_in(pin_in));

    gpm_pin_mux gpm_pin_mux_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .periph_en(periph_en), .sel_a4(sel_a4), .sel_a5(sel_a5), .sel_b(sel_b), .ext_clk_en(ext_clk_en),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in), .pwm_out(pwm_out),
        .pwm_fault_in(pwm_fault_in), .timer_out(timer_out), .timer_oe(timer_oe), .timer_in(timer_in),
        .spi_out(spi_out), .spi_oe(spi_oe), .spi_in(spi_in), .i2c_out(i2c_out), .i2c_oe(i2c_oe),
        .i2c_in(i2c_in), .uart_tx_out(uart_tx_out), .uart_rx_in(uart_rx_in), .clk_out_src(clk_out_src),
        .ext_clk_in(ext_clk_in), .reset_in_n(reset_in_n), .adc_pin_en(adc_pin_en),
        .jtag_tdo_out(jtag_tdo_out), .jtag_tdo_oe(jtag_tdo_oe), .jtag_in(jtag_in));

    ////////////////////////////////////////////////////////////////////////
    // Inputs change a fixed 2 ns after the edge; outputs are read there too
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask

    task automatic end_of_test();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check_idle();
        `CHK(pin_oe, 28'h0000000)
        `CHK(adc_pin_en, 8'hff)
        `CHK(jtag_in, 3'h5)
        `CHK({spi_in, i2c_in, uart_rx_in, reset_in_n}, {4'h2, 2'h3, 1'h1, 1'h1})
    endtask

    // Watchdog: fires after 2000 cycles; the whole run needs 86 cycles
    initial begin
        #(25 * 2000);
        num_errors++;
        end_of_test();
    end

    logic [7:0] b_out [2] = '{8'h9a, 8'h46};
    logic [7:0] b_oe  [2] = '{8'hbf, 8'hdf};
    logic [1:0] a_oe  [4] = '{2'h3, 2'h0, 2'h3, 2'h3};
    logic [1:0] a_out [4] = '{2'h3, 2'h0, 2'h1, 2'h3};

    initial begin
        step(1);
        check_idle();
        step(3);
        sys_rst = 1'b0;
        // GPIO owns A except A7, and B; unbonded A3/A6 never drive
        gpio_oe  = 28'hfffffff;
        gpio_out = 28'h000a5c3;
        step(LAT);
        `CHK(pin_oe[15:0], gpm_pkg::BONDED[15:0] & 16'hff7f)
        `CHK(pin_out[15:0] & 16'hff37, 16'ha5c3 & 16'hff37)
        `CHK(pin_oe[27:16], 12'h200)
        `CHK(pin_out[25], 1'b1)
        `CHK(adc_pin_en, 8'hff)
        gpio_oe = '0;
        ext_en  = 28'hfffffff;
        ext_val = 28'h4053c5a;
        step(LAT);
        `CHK(gpio_in[15:0], 16'h3c5a & gpm_pkg::BONDED[15:0])
        `CHK(jtag_in, 3'h2)
        `CHK(reset_in_n, 1'b0)
        $display("test gpio and reset functions done");
        // Port A bits 4 and 5, every select code
        periph_en = gpm_pkg::FN_RST | 28'h0000030;
        ext_val   = 28'h00000b0;
        for (int s = 0; s < 4; s++) begin
            sel_a4 = 2'(s);
            sel_a5 = 2'(s);
            step(LAT);
            `CHK(pin_oe[5:4], a_oe[s])
            `CHK(pin_out[5:4] & a_oe[s], a_out[s])
            `CHK(pwm_fault_in[2:1], (s == 1) ? 2'h3 : 2'h0)
            `CHK(timer_in[3:2], (s == 2) ? 2'h1 : 2'h0)
        end
        `CHK(reset_in_n, 1'b1)
        $display("test port a selects done");
        // Port B, both alternatives of every bit
        periph_en = gpm_pkg::FN_RST | 28'h000ff00;
        ext_val   = '0;
        sel_b     = 8'h00;
        step(LAT);
        `CHK(pin_oe[15:8], b_oe[0])
        `CHK(pin_out[15:8] & b_oe[0], b_out[0])
        `CHK(uart_rx_in, 1'b0)
        `CHK(pwm_fault_in[3], 1'b0)
        `CHK(spi_in, 4'ha)
        `CHK(timer_in, 4'h1)
        sel_b   = 8'hff;
        ext_val = 28'h0002000;
        step(LAT);
        `CHK(pin_oe[15:8], b_oe[1])
        `CHK(pin_out[15:8] & b_oe[1], b_out[1])
        `CHK(pwm_fault_in[3], 1'b1)
        `CHK(i2c_in, 2'h2)
        `CHK(timer_in, 4'h4)
        `CHK(uart_rx_in, 1'b1)
        // External clock input overrides the B6 select
        ext_clk_en = 1'b1;
        ext_val    = 28'h0004000;
        step(LAT);
        `CHK(pin_oe[14], 1'b0)
        `CHK(ext_clk_in, 1'b1)
        ext_clk_en = 1'b0;
        step(LAT);
        `CHK(ext_clk_in, 1'b0)
        `CHK(pin_oe[14], 1'b1)
        $display("test port b selects done");
        // Back to GPIO, then reset again in mid-run
        periph_en = 28'h0000000;
        step(LAT);
        `CHK(adc_pin_en, 8'h00)
        `CHK(reset_in_n, 1'b1)
        `CHK(pin_oe[15:8], 8'h00)
        sys_rst = 1'b1;
        step(1);
        check_idle();
        periph_en = gpm_pkg::FN_RST;
        step(2);
        sys_rst = 1'b0;
        step(2);
        `CHK(pin_oe[15:0], 16'h0000)
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule
